// File: mggcd_pkg.sv
package mggcd_pkg;

  // ---------------------------------------------------------------
  // command identifiers
  // ---------------------------------------------------------------
  localparam logic [7:0] ID_UNLOCK = 8'h11;
  localparam logic [7:0] ID_GAIN   = 8'h12;
  localparam logic [7:0] ID_GATE   = 8'h13;
  localparam logic [7:0] ID_HOLD   = 8'h14;
  localparam logic [7:0] ID_RATIO  = 8'h17;
  localparam logic [7:0] ID_REPORT = 8'h19;
  localparam logic [7:0] ID_GATING_GROUP_SELECT_CMD = 8'h23;

  // ---------------------------------------------------------------
  // argument fields and ranges
  // ---------------------------------------------------------------
  localparam logic [2:0]  UNLOCK_WORDS = 3'h2;
  localparam int          NKEYS        = 5;
  localparam logic [7:0]  KEY_MIN      = 8'h01;
  localparam logic [7:0]  KEY_MAX      = 8'h04;
  localparam logic [7:0]  GRP_IN       = 8'h01;
  localparam logic [7:0]  GRP_OUT      = 8'h02;
  localparam logic [7:0]  GRP_MIC      = 8'h03;
  localparam logic [7:0]  GRP_PROC     = 8'h05;
  localparam logic [7:0]  GRP_LINE     = 8'h07;
  // gain in tenths of a dB
  localparam logic signed [15:0] GAIN_ENTRY_MAX = 16'sh03E7;
  localparam logic signed [15:0] GAIN_ENTRY_MIN = 16'shFC19;
  localparam logic signed [16:0] GAIN_MAX       = 17'sh000C8;
  localparam logic signed [16:0] GAIN_MIN       = 17'sh1FD76;
  // hold in hundredths of a second
  localparam logic [15:0] HOLD_MIN     = 16'h000A;
  localparam logic [15:0] HOLD_MAX     = 16'h0320;
  localparam logic [15:0] RATIO_MAX    = 16'h0032;
  localparam logic [15:0] GGRP_MIN     = 16'h0001;
  localparam logic [15:0] GGRP_MAX     = 16'h0008;
  localparam logic [31:0] REPORT_OFF   = 32'h0000_0000;
  localparam logic [31:0] REPORT_ON    = 32'h0000_0001;
  localparam logic [31:0] REPORT_TGL   = 32'h0000_0002;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] GAIN_RST  = 16'h0000;
  localparam logic [15:0] HOLD_RST  = 16'h0064;
  localparam logic [7:0]  RATIO_RST = 8'h00;
  localparam logic [3:0]  GGRP_RST  = 4'h1;

  // ---------------------------------------------------------------
  // register map and status bits
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK   = 4'h4;
  localparam logic [3:0] REG_CTRL   = 4'h8;
  localparam logic [3:0] REG_GATE   = 4'hC;
  localparam int ST_CMD    = 0;
  localparam int ST_REJECT = 1;
  localparam int ST_UNLOCK = 2;
  localparam int ST_GATE   = 3;
  localparam int CTRL_REPORT = 0;
  localparam int CTRL_RELOCK = 1;

  typedef enum logic {PNL_LOCKED, PNL_UNLOCKED} mggcd_pnl_type;

endpackage : mggcd_pkg

// File: mggcd_top.sv
// The address-and-strobe port and the register addresses are this design's own decisions.
module mggcd_top import mggcd_pkg::*; #(
  parameter int NCH = 16                   // channels per gain group
) (
  input  wire logic        clk,            // 40 MHz clock
  input  wire logic        rst,            // sync reset, active high
  input  wire logic        cmd_valid,      // command strobe
  input  wire logic [7:0]  cmd_id,         // command identifier
  input  wire logic [2:0]  cmd_words,      // argument words received
  input  wire logic [31:0] cmd_arg0,       // first argument word
  input  wire logic [31:0] cmd_arg1,       // second argument word
  input  wire logic        cmd_has_value,  // value present (not null)
  input  wire logic        cmd_text,       // text form
  input  wire logic        cmd_clear,      // clear keyword
  input  wire logic        cmd_abs,        // gain marked absolute
  output logic             rsp_valid,      // reply strobe
  output logic [7:0]       rsp_id,         // reply identifier
  output logic [31:0]      rsp_arg0,       // reply word 0
  output logic [31:0]      rsp_arg1,       // reply word 1
  output logic             rsp_reject,     // request was refused
  output logic             rsp_mute,       // gain channel muted
  input  wire logic [7:0]  gate_on_in,     // mic gate-on flags
  input  wire logic [3:0]  line_sig_in,    // line 9-12 signal presence
  input  wire logic        key_valid,      // panel key press strobe
  input  wire logic [7:0]  key_code,       // panel key code
  output logic             panel_unlocked, // front panel usable
  input  wire logic [3:0]  reg_addr,       // register byte address
  input  wire logic [31:0] reg_wdata,      // register write data
  input  wire logic        reg_wr,         // register write strobe
  input  wire logic        reg_rd,         // register read strobe
  output logic [31:0]      reg_rdata,      // read data, next cycle
  output logic             irq             // level interrupt
);

  localparam int CHW  = $clog2(NCH);
  localparam int NMIC = 8;

  typedef struct packed {
    mggcd_pnl_type                   pnl;
    logic [2:0]                      key_idx;
    logic [NKEYS-1:0][7:0]           code;
    logic [4:0][NCH-1:0][15:0]       gain;
    logic [4:0][NCH-1:0]             mute;
    logic [NMIC-1:0][15:0]           hold;
    logic [NMIC-1:0][7:0]            ratio;
    logic [NMIC-1:0][3:0]            ggrp;
    logic                            report;
    logic [7:0]                      gate_prev;
    logic                            report_pend;
    logic                            rsp_valid;
    logic [7:0]                      rsp_id;
    logic [31:0]                     rsp_arg0;
    logic [31:0]                     rsp_arg1;
    logic                            rsp_reject;
    logic                            rsp_mute;
    logic [3:0]                      status;
    logic [3:0]                      mask;
    logic [31:0]                     rdata;
  } mggcd_state_type;

  mggcd_state_type st_r;
  mggcd_state_type st_nxt;

  // ---------------------------------------------------------------
  // argument decode
  // ---------------------------------------------------------------
  logic [7:0]         a_ch;
  logic [7:0]         a_grp;
  logic [15:0]        a_val;
  logic [CHW-1:0]     ci;
  logic [2:0]         mi;
  logic [2:0]         gi;
  logic               gi_ok;
  logic               ch_ok;
  logic               mic_ok;
  logic [NKEYS-1:0][7:0] req_code;
  logic               keys_ok;

  assign a_ch  = cmd_arg0[31:24];
  assign a_grp = cmd_arg0[23:16];
  assign a_val = cmd_arg0[15:0];
  assign ci    = CHW'(a_ch - 8'h01);
  assign mi    = 3'(a_ch - 8'h01);
  assign ch_ok = (a_ch != 8'h00) && ({24'h0, a_ch} <= 32'(NCH));
  assign mic_ok = (a_ch != 8'h00) && ({24'h0, a_ch} <= 32'(NMIC)) && (a_grp == GRP_MIC);
  assign req_code = {cmd_arg0, cmd_arg1[31:24]};

  always_comb begin
    gi    = 3'h0;
    gi_ok = 1'b1;
    unique case (a_grp)
      GRP_IN:   gi = 3'h0;
      GRP_OUT:  gi = 3'h1;
      GRP_MIC:  gi = 3'h2;
      GRP_PROC: gi = 3'h3;
      GRP_LINE: gi = 3'h4;
      default:  gi_ok = 1'b0;
    endcase
  end

  always_comb begin
    keys_ok = (cmd_arg1[23:0] == 24'h0);
    for (int k = 0; k < NKEYS; k++) begin
      if (req_code[k] < KEY_MIN || req_code[k] > KEY_MAX) begin
        keys_ok = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic signed [15:0] gval;
    logic signed [16:0] gcur;
    logic signed [16:0] gsum;
    logic [3:0]         ev;
    logic [3:0]         rd_clr;
    gval   = signed'(a_val);
    gcur   = 17'(signed'(st_r.gain[gi][ci]));
    gsum   = 17'sh0;
    ev     = 4'h0;
    rd_clr = 4'h0;
    st_nxt = st_r;
    st_nxt.rsp_valid  = 1'b0;
    st_nxt.rsp_reject = 1'b0;
    st_nxt.rsp_mute   = 1'b0;
    st_nxt.rsp_arg1   = 32'h0;
    st_nxt.gate_prev  = gate_on_in;
    if (st_r.report && (gate_on_in != st_r.gate_prev)) begin
      st_nxt.report_pend = 1'b1;
      ev[ST_GATE]        = 1'b1;
    end

    if (cmd_valid) begin
      st_nxt.rsp_valid = 1'b1;
      st_nxt.rsp_id    = cmd_id;
      st_nxt.rsp_arg0  = cmd_arg0;
      ev[ST_CMD]       = 1'b1;
      unique case (cmd_id)
        ID_UNLOCK: begin
          if (cmd_clear) begin
            st_nxt.code = '0;
          end else if (cmd_has_value) begin
            if (cmd_words == UNLOCK_WORDS && keys_ok) begin
              st_nxt.code = req_code;
            end else begin
              st_nxt.rsp_reject = 1'b1;
            end
          end
          // reply carries the code as it stands after the command
          st_nxt.rsp_arg0 = st_nxt.code[4:1];
          st_nxt.rsp_arg1 = {st_nxt.code[0], 24'h0};
        end
        ID_GAIN: begin
          if (!(ch_ok && gi_ok)) begin
            st_nxt.rsp_reject = 1'b1;
          end else begin
            if (cmd_has_value) begin
              if (gval > GAIN_ENTRY_MAX || gval < GAIN_ENTRY_MIN) begin
                st_nxt.rsp_reject = 1'b1;
              end else begin
                // unmarked values arrive with cmd_abs low and add on
                gsum = cmd_abs ? 17'(gval) : 17'(gcur + 17'(gval));
                if (gsum < GAIN_MIN) begin
                  st_nxt.gain[gi][ci] = GAIN_MIN[15:0];
                  st_nxt.mute[gi][ci] = 1'b1;
                end else if (gsum > GAIN_MAX) begin
                  st_nxt.gain[gi][ci] = GAIN_MAX[15:0];
                  st_nxt.mute[gi][ci] = 1'b0;
                end else begin
                  st_nxt.gain[gi][ci] = gsum[15:0];
                  st_nxt.mute[gi][ci] = 1'b0;
                end
              end
            end
            st_nxt.rsp_arg0 = {a_ch, a_grp, st_nxt.gain[gi][ci]};
            st_nxt.rsp_mute = st_nxt.mute[gi][ci];
          end
        end
        ID_HOLD: begin
          if (!mic_ok) begin
            st_nxt.rsp_reject = 1'b1;
          end else begin
            if (cmd_has_value) begin
              if (a_val >= HOLD_MIN && a_val <= HOLD_MAX) begin
                st_nxt.hold[mi] = a_val;
              end else begin
                st_nxt.rsp_reject = 1'b1;
              end
            end
            st_nxt.rsp_arg0 = {a_ch, a_grp, st_nxt.hold[mi]};
          end
        end
        ID_GATE: begin
          // read only: nothing stored is touched here
          st_nxt.rsp_arg0 = {24'h0, gate_on_in};
          if (cmd_text) begin
            st_nxt.rsp_arg0 = {20'h0, line_sig_in, gate_on_in};
          end
        end
        ID_RATIO: begin
          if (!mic_ok) begin
            st_nxt.rsp_reject = 1'b1;
          end else begin
            if (cmd_has_value) begin
              if (a_val <= RATIO_MAX) begin
                st_nxt.ratio[mi] = a_val[7:0];
              end else begin
                st_nxt.rsp_reject = 1'b1;
              end
            end
            st_nxt.rsp_arg0 = {a_ch, a_grp, 8'h00, st_nxt.ratio[mi]};
          end
        end
        ID_REPORT: begin
          if (cmd_has_value) begin
            if (cmd_arg0 == REPORT_OFF) begin
              st_nxt.report = 1'b0;
            end else if (cmd_arg0 == REPORT_ON) begin
              st_nxt.report = 1'b1;
            end else if (cmd_arg0 == REPORT_TGL) begin
              st_nxt.report = !st_r.report;
            end else begin
              st_nxt.rsp_reject = 1'b1;
            end
          end
          st_nxt.rsp_arg0 = {31'h0, st_nxt.report};
        end
        ID_GATING_GROUP_SELECT_CMD: begin
          if (!mic_ok) begin
            st_nxt.rsp_reject = 1'b1;
          end else begin
            if (cmd_has_value) begin
              if (a_val >= GGRP_MIN && a_val <= GGRP_MAX) begin
                st_nxt.ggrp[mi] = a_val[3:0];
              end else begin
                st_nxt.rsp_reject = 1'b1;
              end
            end
            st_nxt.rsp_arg0 = {a_ch, a_grp, 12'h0, st_nxt.ggrp[mi]};
          end
        end
        default: st_nxt.rsp_reject = 1'b1;
      endcase
      ev[ST_REJECT] = st_nxt.rsp_reject;
    end else if (st_r.report_pend) begin
      // unsolicited reports wait for a cycle with no command
      st_nxt.rsp_valid   = 1'b1;
      st_nxt.rsp_id      = ID_GATE;
      st_nxt.rsp_arg0    = {24'h0, gate_on_in};
      // a change in this very cycle keeps a report pending
      st_nxt.report_pend = ev[ST_GATE];
    end

    // panel unlock sequence; a wrong key may still start a new try
    if (key_valid && st_r.pnl == PNL_LOCKED) begin
      if (key_code == st_r.code[3'(4) - st_r.key_idx]) begin
        if (st_r.key_idx == 3'(NKEYS - 1)) begin
          st_nxt.pnl     = PNL_UNLOCKED;
          st_nxt.key_idx = 3'h0;
          ev[ST_UNLOCK]  = 1'b1;
        end else begin
          st_nxt.key_idx = st_r.key_idx + 3'h1;
        end
      end else begin
        st_nxt.key_idx = (key_code == st_r.code[4]) ? 3'h1 : 3'h0;
      end
    end

    // register port
    st_nxt.rdata = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS: begin
          st_nxt.rdata = {28'h0, st_r.status};
          rd_clr       = st_r.status;
        end
        REG_MASK:   st_nxt.rdata = {28'h0, st_r.mask};
        REG_CTRL:   st_nxt.rdata = {30'h0, panel_unlocked, st_r.report};
        REG_GATE:   st_nxt.rdata = {20'h0, line_sig_in, gate_on_in};
        default:    st_nxt.rdata = 32'h0;
      endcase
    end
    if (reg_wr && reg_addr == REG_MASK) begin
      st_nxt.mask = reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == REG_CTRL && !cmd_valid) begin
      // a command in the same cycle owns the report mode
      st_nxt.report = reg_wdata[CTRL_REPORT];
    end
    if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_RELOCK]) begin
      st_nxt.pnl     = PNL_LOCKED;
      st_nxt.key_idx = 3'h0;
    end
    // a new event wins over the read that clears it
    st_nxt.status = (st_r.status & ~rd_clr) | ev;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r           <= '0;
      st_r.pnl       <= PNL_LOCKED;
      st_r.gain      <= {(5 * NCH){GAIN_RST}};
      st_r.hold      <= {NMIC{HOLD_RST}};
      st_r.ratio     <= {NMIC{RATIO_RST}};
      st_r.ggrp      <= {NMIC{GGRP_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp_valid      = st_r.rsp_valid;
  assign rsp_id         = st_r.rsp_id;
  assign rsp_arg0       = st_r.rsp_arg0;
  assign rsp_arg1       = st_r.rsp_arg1;
  assign rsp_reject     = st_r.rsp_reject;
  assign rsp_mute       = st_r.rsp_mute;
  assign reg_rdata      = st_r.rdata;
  assign irq            = |(st_r.status & st_r.mask);
  // an erased code leaves the panel open
  assign panel_unlocked = (st_r.pnl == PNL_UNLOCKED) || (st_r.code == '0);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_unlock_set;
    cmd_valid && cmd_id == ID_UNLOCK && cmd_has_value && !cmd_clear;
  endsequence
  sequence s_wrong_key;
    key_valid && st_r.pnl == PNL_LOCKED && key_code != st_r.code[3'(4) - st_r.key_idx];
  endsequence

  a_unlock_len: assert property (
    s_unlock_set and (cmd_words != UNLOCK_WORDS) |=> rsp_valid && rsp_reject)
    else $error("unlock code of wrong length accepted");
  a_unlock_keys: assert property (
    s_unlock_set and !keys_ok |=> rsp_reject && $stable(st_r.code))
    else $error("bad key field changed the code");
  a_clear_code: assert property (
    cmd_valid && cmd_id == ID_UNLOCK && cmd_clear |=> st_r.code == '0 && panel_unlocked)
    else $error("clear did not erase the code");
  a_unlock_echo: assert property (
    cmd_valid && cmd_id == ID_UNLOCK |=> rsp_arg0 == st_r.code[4:1]
      && rsp_arg1 == {st_r.code[0], 24'h0})
    else $error("unlock reply differs from stored code");
  a_gain_clamp: assert property (
    rsp_valid && rsp_id == ID_GAIN && !rsp_reject |-> signed'(rsp_arg0[15:0]) <= 16'sh00C8
      && signed'(rsp_arg0[15:0]) >= 16'shFD76 && (!rsp_mute || rsp_arg0[15:0] == 16'hFD76))
    else $error("gain outside internal range");
  a_gain_rel: assert property (
    cmd_valid && cmd_id == ID_GAIN && cmd_has_value && !cmd_abs && ch_ok && gi_ok
      && a_val == 16'h0000 |=> rsp_arg0[15:0] == $past(st_r.gain[gi][ci]))
    else $error("relative zero changed the gain");
  a_hold_range: assert property (
    rsp_valid && rsp_id == ID_HOLD && !rsp_reject |-> rsp_arg0[15:0] >= HOLD_MIN
      && rsp_arg0[15:0] <= HOLD_MAX)
    else $error("hold time outside range");
  a_gate_ro: assert property (
    cmd_valid && cmd_id == ID_GATE |=> rsp_arg0[7:0] == $past(gate_on_in)
      && $stable(st_r.hold) && $stable(st_r.ggrp))
    else $error("gate status request disturbed state");
  a_report_tgl: assert property (
    cmd_valid && cmd_id == ID_REPORT && cmd_has_value && cmd_arg0 == REPORT_TGL
      |=> st_r.report != $past(st_r.report) ##0 rsp_arg0[0] == st_r.report)
    else $error("toggle did not invert report mode");
  a_grp_range: assert property (
    cmd_valid && cmd_id == ID_GATING_GROUP_SELECT_CMD && cmd_has_value && mic_ok
      && (a_val == 16'h0000 || a_val > 16'h0008) |=> rsp_reject && $stable(st_r.ggrp))
    else $error("illegal gating group accepted");
  a_key_wrong: assert property (
    s_wrong_key |=> st_r.pnl == PNL_LOCKED)
    else $error("wrong key unlocked the panel");
  a_reject_keep: assert property (
    rsp_valid && rsp_reject |-> $stable(st_r.ratio) && $stable(st_r.hold) && $stable(st_r.gain))
    else $error("rejected request changed a setting");

endmodule : mggcd_top

// File: mggcd_host.sv
module mggcd_host (
  input  wire logic        clk,           // system clock
  output logic             cmd_valid,     // command strobe
  output logic [7:0]       cmd_id,        // command identifier
  output logic [2:0]       cmd_words,     // argument words
  output logic [31:0]      cmd_arg0,      // first argument word
  output logic [31:0]      cmd_arg1,      // second argument word
  output logic             cmd_has_value, // value present
  output logic             cmd_text,      // text form
  output logic             cmd_clear,     // clear keyword
  output logic             cmd_abs        // gain marked absolute
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cmd_valid = 1'b0;
    cmd_id = 8'h00;
    cmd_words = 3'h0;
    cmd_arg0 = 32'h0;
    cmd_arg1 = 32'h0;
    {cmd_has_value, cmd_text, cmd_clear, cmd_abs} = 4'h0;
  end

  // ---------------------------------------------------------------
  // one command: strobe for one cycle, fields held alongside it
  // ---------------------------------------------------------------
  task automatic send(input logic [7:0] id, input logic [2:0] w,
                      input logic [31:0] a0, a1, input logic [3:0] f);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_id <= id;
    cmd_words <= w;
    cmd_arg0 <= a0;
    cmd_arg1 <= a1;
    {cmd_has_value, cmd_text, cmd_clear, cmd_abs} <= f;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // stale words are inverted so sampling outside the strobe shows up
    cmd_arg0 <= ~a0;
    cmd_arg1 <= ~a1;
    cmd_id <= ~id;
  endtask : send
endmodule : mggcd_host

// File: mixer_gate_gain_command_decoder_bench.sv
module mixer_gate_gain_command_decoder_bench import mggcd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        rst, cmd_valid, cmd_has_value, cmd_text, cmd_clear, cmd_abs;
  logic [7:0]  cmd_id, rsp_id, gate_on_in, key_code;
  logic [2:0]  cmd_words;
  logic [31:0] cmd_arg0, cmd_arg1, rsp_arg0, rsp_arg1, reg_wdata, reg_rdata;
  logic        rsp_valid, rsp_reject, rsp_mute, key_valid, panel_unlocked;
  logic        reg_wr, reg_rd, irq, mute_seen;
  logic [3:0]  line_sig_in, reg_addr;
  int          miscompares = 0;
  int          comparisons = 0;

  always #12.5 clk = ~clk;

  mggcd_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd_id(cmd_id), .cmd_words(cmd_words),
    .cmd_arg0(cmd_arg0), .cmd_arg1(cmd_arg1), .cmd_has_value(cmd_has_value),
    .cmd_text(cmd_text), .cmd_clear(cmd_clear), .cmd_abs(cmd_abs));

  mggcd_top #(.NCH(16)) dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_id(cmd_id),
    .cmd_words(cmd_words), .cmd_arg0(cmd_arg0), .cmd_arg1(cmd_arg1),
    .cmd_has_value(cmd_has_value), .cmd_text(cmd_text), .cmd_clear(cmd_clear),
    .cmd_abs(cmd_abs), .rsp_valid(rsp_valid), .rsp_id(rsp_id), .rsp_arg0(rsp_arg0),
    .rsp_arg1(rsp_arg1), .rsp_reject(rsp_reject), .rsp_mute(rsp_mute),
    .gate_on_in(gate_on_in), .line_sig_in(line_sig_in), .key_valid(key_valid),
    .key_code(key_code), .panel_unlocked(panel_unlocked), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  // f = {has_value, text, clear, absolute}
  task automatic cmd(input logic [7:0] id, input logic [31:0] a0, a1, input logic [2:0] w,
                     input logic [3:0] f, input logic [31:0] e0, e1, input logic rj);
    host.send(id, w, a0, a1, f);
    @(negedge clk);
    chk("rsp_valid", 32'h1, rsp_valid);
    chk("rsp_id", id, rsp_id);
    chk("rsp_arg0", e0, rsp_arg0);
    chk("rsp_arg1", e1, rsp_arg1);
    chk("rsp_reject", rj, rsp_reject);
    mute_seen = rsp_mute;
  endtask : cmd

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(nm, e, reg_rdata);
  endtask : rd_reg

  task automatic keys(input logic [39:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      key_valid <= 1'b1;
      key_code <= s[39-8*i -: 8];
      @(posedge clk);
      key_valid <= 1'b0;
    end
    repeat (2) @(negedge clk);
  endtask : keys

  task automatic conclude;
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // under two hundred cycles are expected; the limit of 4000 is generous
  initial begin
    #(25 * 4000);
    miscompares++;
    conclude();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {key_valid, key_code, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    gate_on_in = 8'h49;
    line_sig_in = 4'h5;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("panel_unlocked", 32'h1, panel_unlocked);
    chk("irq", 32'h0, irq);
    rd_reg(REG_MASK, 32'h0, "mask reset");
    rd_reg(REG_CTRL, 32'h2, "ctrl reset");
    cmd(ID_HOLD, 32'h02030000, 32'h0, 3'h1, 4'h0, 32'h02030064, 32'h0, 1'b0);
    cmd(ID_HOLD, 32'h010300C8, 32'h0, 3'h1, 4'h8, 32'h010300C8, 32'h0, 1'b0);
    @(negedge clk);
    chk("rsp_valid low", 32'h0, rsp_valid);
    cmd(ID_HOLD, 32'h01030000, 32'h0, 3'h1, 4'h0, 32'h010300C8, 32'h0, 1'b0);
    cmd(ID_HOLD, 32'h01030009, 32'h0, 3'h1, 4'h8, 32'h010300C8, 32'h0, 1'b1);
    cmd(ID_HOLD, 32'h01030320, 32'h0, 3'h1, 4'h8, 32'h01030320, 32'h0, 1'b0);
    cmd(ID_HOLD, 32'h01030321, 32'h0, 3'h1, 4'h8, 32'h01030320, 32'h0, 1'b1);
    cmd(ID_HOLD, 32'h090300C8, 32'h0, 3'h1, 4'h8, 32'h090300C8, 32'h0, 1'b1);
    cmd(ID_GAIN, 32'h04020078, 32'h0, 3'h1, 4'h9, 32'h04020078, 32'h0, 1'b0);
    cmd(ID_GAIN, 32'h0402FFE2, 32'h0, 3'h1, 4'h8, 32'h0402005A, 32'h0, 1'b0);
    cmd(ID_GAIN, 32'h0402FC19, 32'h0, 3'h1, 4'h9, 32'h0402FD76, 32'h0, 1'b0);
    chk("rsp_mute", 32'h1, mute_seen);
    cmd(ID_GAIN, 32'h040203E7, 32'h0, 3'h1, 4'h8, 32'h040200C8, 32'h0, 1'b0);
    chk("rsp_mute", 32'h0, mute_seen);
    cmd(ID_GAIN, 32'h040203E8, 32'h0, 3'h1, 4'h9, 32'h040200C8, 32'h0, 1'b1);
    cmd(ID_GAIN, 32'h04020000, 32'h0, 3'h1, 4'h8, 32'h040200C8, 32'h0, 1'b0);
    cmd(8'h30, 32'h12345678, 32'h0, 3'h1, 4'h8, 32'h12345678, 32'h0, 1'b1);
    cmd(ID_GATE, 32'hFFFFFFFF, 32'h0, 3'h1, 4'h8, 32'h00000049, 32'h0, 1'b0);
    cmd(ID_GATE, 32'h0, 32'h0, 3'h1, 4'h4, 32'h00000549, 32'h0, 1'b0);
    rd_reg(REG_GATE, 32'h549, "gate reg");
    cmd(ID_RATIO, 32'h01030000, 32'h0, 3'h1, 4'h0, 32'h01030000, 32'h0, 1'b0);
    cmd(ID_RATIO, 32'h01030032, 32'h0, 3'h1, 4'h8, 32'h01030032, 32'h0, 1'b0);
    cmd(ID_RATIO, 32'h01030033, 32'h0, 3'h1, 4'h8, 32'h01030032, 32'h0, 1'b1);
    cmd(ID_RATIO, 32'h01030000, 32'h0, 3'h1, 4'h0, 32'h01030032, 32'h0, 1'b0);
    cmd(ID_REPORT, REPORT_ON, 32'h0, 3'h1, 4'h8, REPORT_ON, 32'h0, 1'b0);
    cmd(ID_REPORT, REPORT_TGL, 32'h0, 3'h1, 4'h8, REPORT_OFF, 32'h0, 1'b0);
    cmd(ID_REPORT, REPORT_TGL, 32'h0, 3'h1, 4'h8, REPORT_ON, 32'h0, 1'b0);
    cmd(ID_REPORT, 32'h3, 32'h0, 3'h1, 4'h8, REPORT_ON, 32'h0, 1'b1);
    // a gate change with reporting on answers unprompted two edges later
    @(posedge clk);
    gate_on_in <= 8'h05;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("report valid", 32'h1, rsp_valid);
    chk("report id", ID_GATE, rsp_id);
    chk("report arg", 32'h05, rsp_arg0);
    cmd(ID_REPORT, REPORT_OFF, 32'h0, 3'h1, 4'h8, REPORT_OFF, 32'h0, 1'b0);
    @(posedge clk);
    gate_on_in <= 8'h49;
    repeat (3) @(negedge clk);
    chk("no report", 32'h0, rsp_valid);
    cmd(ID_GATING_GROUP_SELECT_CMD, 32'h03030000, 32'h0, 3'h1, 4'h0, 32'h03030001, 32'h0, 1'b0);
    cmd(ID_GATING_GROUP_SELECT_CMD, 32'h02030008, 32'h0, 3'h1, 4'h8, 32'h02030008, 32'h0, 1'b0);
    cmd(ID_GATING_GROUP_SELECT_CMD, 32'h02030009, 32'h0, 3'h1, 4'h8, 32'h02030008, 32'h0, 1'b1);
    cmd(ID_GATING_GROUP_SELECT_CMD, 32'h02030000, 32'h0, 3'h1, 4'h8, 32'h02030008, 32'h0, 1'b1);
    cmd(ID_GATING_GROUP_SELECT_CMD, 32'h02030003, 32'h0, 3'h1, 4'h8, 32'h02030003, 32'h0, 1'b0);
    cmd(ID_GATING_GROUP_SELECT_CMD, 32'h02030000, 32'h0, 3'h1, 4'h0, 32'h02030003, 32'h0, 1'b0);
    cmd(ID_UNLOCK, 32'h01010404, 32'h02000000, 3'h2, 4'h8, 32'h01010404, 32'h02000000, 1'b0);
    cmd(ID_UNLOCK, 32'h0, 32'h0, 3'h2, 4'h0, 32'h01010404, 32'h02000000, 1'b0);
    cmd(ID_UNLOCK, 32'h01010405, 32'h02000000, 3'h2, 4'h8, 32'h01010404, 32'h02000000, 1'b1);
    cmd(ID_UNLOCK, 32'h01010404, 32'h02000001, 3'h2, 4'h8, 32'h01010404, 32'h02000000, 1'b1);
    cmd(ID_UNLOCK, 32'h01010404, 32'h02000000, 3'h1, 4'h8, 32'h01010404, 32'h02000000, 1'b1);
    wr_reg(REG_CTRL, 32'h2);
    chk("panel_unlocked", 32'h0, panel_unlocked);
    keys(40'h0101040302, 4);
    chk("panel_unlocked", 32'h0, panel_unlocked);
    keys(40'h0101040402, 5);
    chk("panel_unlocked", 32'h1, panel_unlocked);
    cmd(ID_UNLOCK, 32'h01010404, 32'h02000000, 3'h2, 4'hA, 32'h0, 32'h0, 1'b0);
    rd_reg(REG_STATUS, 32'hF, "status");
    wr_reg(REG_MASK, 32'h2);
    rd_reg(REG_MASK, 32'h2, "mask");
    cmd(ID_RATIO, 32'h01030040, 32'h0, 3'h1, 4'h8, 32'h01030032, 32'h0, 1'b1);
    repeat (2) @(negedge clk);
    chk("irq", 32'h1, irq);
    wr_reg(REG_MASK, 32'h0);
    chk("irq masked", 32'h0, irq);
    wr_reg(REG_MASK, 32'h2);
    chk("irq", 32'h1, irq);
    rd_reg(REG_STATUS, 32'h3, "status");
    @(negedge clk);
    chk("irq cleared", 32'h0, irq);
    rd_reg(4'h2, 32'h0, "unmapped");
    rd_reg(REG_CTRL, 32'h2, "ctrl");
    conclude();
  end
endmodule : mixer_gate_gain_command_decoder_bench
